// >>> rtl/pad_pkg.sv
package pad_pkg;
    // register map
    localparam logic [7:0]  PAD_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  PAD_STAT_OFS     = 8'h04;
    // control field positions
    localparam int          PAD_CTRL_ROM_CAPACITY_BIT   = 0;
    localparam int          PAD_CTRL_DRAM_CAPACITY_BIT  = 1;
    localparam int          PAD_CTRL_HSWIN   = 2;
    localparam int          PAD_CTRL_HSW_LO  = 4;
    localparam int          PAD_CTRL_SYW_LO  = 8;
    localparam int          PAD_WAIT_W       = 4;
    localparam logic [31:0] PAD_CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] PAD_CTRL_MASK    = 32'h0000_0FF7;
    // status field positions
    localparam int          PAD_STAT_BUS32   = 0;
    localparam int          PAD_STAT_RGN_LO  = 4;
    // space codes on physical address bits 28..24
    localparam logic [4:0]  PAD_SHARED_HI    = 5'h0A;
    localparam logic [4:0]  PAD_IO2_HI       = 5'h0B;
    localparam logic [4:0]  PAD_IO1_HI       = 5'h0C;
    // space codes on bits 28..26
    localparam logic [2:0]  PAD_DRAM_HI      = 3'h0;
    localparam logic [2:0]  PAD_ISAMEM_HI    = 3'h4;
    localparam logic [2:0]  PAD_ISAIO_HI     = 3'h5;
    // rom space: bits 28..27 both set
    localparam logic [1:0]  PAD_ROM_HI       = 2'h3;
    // fixed pattern on external address 25..24 for the fast window
    localparam logic [1:0]  PAD_HS_ADDR_HI   = 2'h2;
    // 32-byte peripheral windows
    localparam int          PAD_IO1_N        = 3;
    localparam int          PAD_IO2_N        = 22;
    // io space 2 windows that are reserved (0x140,0x1E0,0x220,0x280)
    localparam logic [21:0] PAD_IO2_USED     = 22'h2D_7BFF;
    // decoded region
    typedef enum logic [3:0] {
        PAD_RGN_NONE   = 4'h0,
        PAD_RGN_DRAM   = 4'h1,
        PAD_RGN_ROM    = 4'h2,
        PAD_RGN_ISAIO  = 4'h3,
        PAD_RGN_ISAMEM = 4'h4,
        PAD_RGN_HSMEM  = 4'h5,
        PAD_RGN_LCD    = 4'h6,
        PAD_RGN_IO1    = 4'h7,
        PAD_RGN_IO2    = 4'h8
    } pad_region_t;
endpackage

// >>> rtl/pad_bank_map.sv
`timescale 1ns/1ps
// rom and dram bank selection from address, bus width and capacities
module pad_bank_map
    import pad_pkg::*;
(
    // address, aliased to 512 Mbytes
    input  wire logic [28:0] addr,
    // layout inputs
    input  wire logic        bus32,
    input  wire logic        rom_capacity_bit,
    input  wire logic        dram_capacity_bit,
    // one-hot bank hits, active high
    output logic      [3:0]  rom_hit,
    output logic      [3:0]  dram_hit
);
    logic       rom_sp;
    logic       rom_in;
    logic [1:0] rom_bank;
    logic       dram_sp;
    logic       dram_in;
    logic [1:0] dram_bank;

    // rom: 0x1800..0x1DFF stays reserved in all layouts
    assign rom_sp = (addr[28:27] == PAD_ROM_HI);
    always_comb begin
        unique case ({bus32, rom_capacity_bit})
            2'b00: begin
                rom_in   = (addr[26:24] == 3'h7);
                rom_bank = addr[23:22];
            end
            2'b01: begin
                rom_in   = (addr[26:25] == 2'h3);
                rom_bank = addr[24:23];
            end
            2'b10: begin
                rom_in   = (addr[26:24] == 3'h7);
                rom_bank = {1'b0, addr[23]};
            end
            2'b11: begin
                rom_in   = (addr[26:25] == 2'h3);
                rom_bank = {1'b0, addr[24]};
            end
        endcase
    end

    // dram: 0x0200..0x03FF always reserved
    assign dram_sp = (addr[28:26] == PAD_DRAM_HI) && !addr[25];
    always_comb begin
        unique case ({bus32, dram_capacity_bit})
            2'b00: begin
                dram_in   = (addr[24:23] == 2'h0);
                dram_bank = addr[22:21];
            end
            2'b01: begin
                dram_in   = 1'b1;
                dram_bank = addr[24:23];
            end
            2'b10: begin
                dram_in   = (addr[24:23] == 2'h0);
                dram_bank = {1'b0, addr[22]};
            end
            2'b11: begin
                dram_in   = 1'b1;
                dram_bank = {1'b0, addr[24]};
            end
        endcase
    end

    // one-hot outputs, nothing in reserved ranges
    assign rom_hit  = (rom_sp && rom_in) ? (4'h1 << rom_bank) : 4'h0;
    assign dram_hit = (dram_sp && dram_in) ? (4'h1 << dram_bank)
                                           : 4'h0;
endmodule

// >>> rtl/pad_decoder.sv
`timescale 1ns/1ps
// Functional notes
// - rom layout follows bus width strap and rom capacity bit.
// - 16-bit, 32-Mbit rom: four 4-Mbyte banks from 0x1F000000.
// - 16-bit, 64-Mbit rom: four 8-Mbyte banks from 0x1E000000.
// - 32-bit, 32-Mbit rom: two 8-Mbyte banks from 0x1F000000.
// - 32-bit, 64-Mbit rom: two 16-Mbyte banks from 0x1E000000.
// - rom addresses 0x18000000 to 0x1DFFFFFF select no bank.
// - fast window is 16 Mbytes; external address 25..24 held at 10.
// - fast system-bus window accesses assert the display select.
// - one control bit picks fast window or display window.
// - data through the display window is bitwise inverted both ways.
// - fast window wait setting independent of system-bus memory.
// - io space 1: uart, modem port, infrared at 32-byte windows.
// - io space 2 first ten 32-byte windows from 0x0B000000.
// - io space 2 later windows with reserved gaps up to 0x0B0002BF.
// - dram layout from strap and capacity bit; upper 32 Mbytes reserved.
// - 16-bit, 16-Mbit dram: four 2-Mbyte banks from zero.
// - 16-bit, 64-Mbit dram: four 8-Mbyte banks from zero.
// - 32-bit, 16-Mbit dram: two 4-Mbyte banks.
// - 32-bit, 64-Mbit dram: two 16-Mbyte banks.
// - addresses above 0x1FFFFFFF alias; only bits 28..0 decode.
// - system-bus io at 0x14000000, memory at 0x10000000, 64 Mbytes.
// - shared display/fast window at 0x0A000000 to 0x0AFFFFFF.
module pad_decoder
    import pad_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,

    // ahb-lite register slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,

    // strap pin
    input  wire logic        bus_width_strap,

    // access from the bus unit
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic [31:0] acc_wdata,
    output logic      [31:0] acc_rdata,

    // external memory side
    output logic      [25:0] ext_addr,
    output logic      [31:0] ext_wdata,
    input  wire logic [31:0] ext_rdata,
    output logic      [3:0]  rom_bank_select_n,
    output logic      [3:0]  dram_row_strobe_n,
    output logic             display_select_n,
    output logic             isa_io_select_n,
    output logic             isa_mem_select_n,
    output logic      [PAD_WAIT_W-1:0] acc_wait,

    // internal peripheral selects
    output logic      [PAD_IO1_N-1:0]  io1_select_n,
    output logic      [PAD_IO2_N-1:0]  io2_select_n,

    // decoded region of the last access
    output pad_region_t      region
);
    // strap synchroniser
    logic [2:0]  strap_sync_r;
    logic        bus32_r;

    // control register
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;

    // ahb data-phase state
    logic        wr_pend_r;
    logic [7:0]  wr_ofs_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;

    // registered decode outputs
    // every pin leaves a flop: no glitch
    logic [25:0] ext_addr_r;
    logic [31:0] ext_wdata_r;
    logic [31:0] acc_rdata_r;
    // selects, active low
    logic [3:0]  rom_n_r;
    logic [3:0]  dram_n_r;
    logic        disp_n_r;
    logic        isaio_n_r;
    logic        isamem_n_r;
    logic [PAD_WAIT_W-1:0] wait_r;
    logic [PAD_IO1_N-1:0]  io1_n_r;
    logic [PAD_IO2_N-1:0]  io2_n_r;
    // last accepted region
    pad_region_t region_r;
    pad_region_t rgn;

    // ahb decode; no wait states
    wire        ahb_go   = hsel && htrans[1] && hready;
    wire [7:0]  ahb_ofs  = haddr[7:0];
    // writes above offset 0xFF are dropped
    wire        ahb_map  = (haddr[31:8] == 24'h00_0000);
    wire        ahb_wr   = ahb_go && hwrite && ahb_map;
    wire        ahb_rd   = ahb_go && !hwrite;

    // control fields
    // change capacity bits only when idle
    wire        rom_capacity_bit    = ctrl_r[PAD_CTRL_ROM_CAPACITY_BIT];
    wire        dram_capacity_bit   = ctrl_r[PAD_CTRL_DRAM_CAPACITY_BIT];
    wire        hs_win   = ctrl_r[PAD_CTRL_HSWIN];
    wire [PAD_WAIT_W-1:0] hs_wait =
        ctrl_r[PAD_CTRL_HSW_LO +: PAD_WAIT_W];
    wire [PAD_WAIT_W-1:0] sy_wait =
        ctrl_r[PAD_CTRL_SYW_LO +: PAD_WAIT_W];

    // address decode on the aliased bits
    // every 512-Mbyte mirror decodes alike
    wire [28:0] a        = acc_addr[28:0];
    wire [4:0]  a_hi5    = a[28:24];
    wire [2:0]  a_hi3    = a[28:26];
    wire        in_isaio = (a_hi3 == PAD_ISAIO_HI);
    wire        in_isamem = (a_hi3 == PAD_ISAMEM_HI);
    // shared window: fast bus or display
    wire        in_shared = (a_hi5 == PAD_SHARED_HI);
    wire        in_hs    = in_shared && hs_win;
    wire        in_lcd   = in_shared && !hs_win;

    // internal windows are 32 bytes each
    wire        in_io1   = (a_hi5 == PAD_IO1_HI) && (a[23:7] == 17'h0);
    wire        in_io2   = (a_hi5 == PAD_IO2_HI) && (a[23:10] == 14'h0);
    wire [1:0]  io1_idx  = a[6:5];
    wire [4:0]  io2_idx  = a[9:5];

    // bank selection
    // layout follows strap and capacity
    logic [3:0] rom_hit;
    logic [3:0] dram_hit;
    pad_bank_map u_map (
        .addr     (a),
        .bus32    (bus32_r),
        .rom_capacity_bit    (rom_capacity_bit),
        .dram_capacity_bit   (dram_capacity_bit),
        .rom_hit  (rom_hit),
        .dram_hit (dram_hit)
    );

    // peripheral window hits, one per window
    // reserved io2 windows masked off
    logic [PAD_IO1_N-1:0] io1_hit;
    logic [PAD_IO2_N-1:0] io2_hit;
    genvar gi;
    generate
        // uart, modem port, infrared
        for (gi = 0; gi < PAD_IO1_N; gi++) begin : g_io1
            assign io1_hit[gi] = in_io1 &&
                (io1_idx == 2'(gi));
        end
        for (gi = 0; gi < PAD_IO2_N; gi++) begin : g_io2
            assign io2_hit[gi] = in_io2 && PAD_IO2_USED[gi] &&
                (io2_idx == 5'(gi));
        end
    endgenerate

    // region classification
    // spaces are disjoint; order is moot
    always_comb begin
        rgn = PAD_RGN_NONE;
        if (|dram_hit)
            rgn = PAD_RGN_DRAM;
        else if (|rom_hit)
            rgn = PAD_RGN_ROM;
        else if (in_isaio)
            rgn = PAD_RGN_ISAIO;
        else if (in_isamem)
            rgn = PAD_RGN_ISAMEM;
        else if (in_hs)
            rgn = PAD_RGN_HSMEM;
        else if (in_lcd)
            rgn = PAD_RGN_LCD;
        else if (|io1_hit)
            rgn = PAD_RGN_IO1;
        else if (|io2_hit)
            rgn = PAD_RGN_IO2;
    end

    // external address: fast window forces the top two bits
    wire [25:0] ext_addr_nxt = in_hs ? {PAD_HS_ADDR_HI, a[23:0]}
                                     : a[25:0];

    // display data is inverted on the way out
    wire [31:0] ext_wdata_nxt = in_lcd ? ~acc_wdata : acc_wdata;

    // wait setting chosen per window
    wire [PAD_WAIT_W-1:0] wait_nxt = in_hs ? hs_wait : sy_wait;

    // display select covers the whole shared window in either mode
    wire        disp_n_nxt = !(in_shared);
    // fast window is system-bus memory
    wire        isamem_n_nxt = !(in_isamem || in_hs);

    // read data trail the select by a cycle
    wire        lcd_last = (region_r == PAD_RGN_LCD);

    // strap pin synchroniser, change taken when stages two and three agree
    // stage one may be metastable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_sync_r <= 3'h0;
            bus32_r      <= 1'b0;
        end else begin
            strap_sync_r <= {strap_sync_r[1:0], bus_width_strap};
            if (strap_sync_r[1] == strap_sync_r[2])
                bus32_r <= strap_sync_r[2];
        end
    end

    // control register write in the data phase
    // unused bits read back as zero
    assign ctrl_nxt = (wr_pend_r && (wr_ofs_r == PAD_CTRL_OFS))
                    ? (hwdata & PAD_CTRL_MASK) : ctrl_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ctrl_r <= PAD_CTRL_RST;
        else
            ctrl_r <= ctrl_nxt;
    end

    // ahb address phase capture
    // haddr moves on in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 8'h00;
        end else begin
            wr_pend_r <= ahb_wr;
            wr_ofs_r  <= ahb_ofs;
        end
    end

    // read mux; unmapped offsets read zero
    // status shows the synchronised strap
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ahb_ofs == PAD_CTRL_OFS)
            rd_mux = ctrl_r;
        else if (ahb_ofs == PAD_STAT_OFS) begin
            rd_mux[PAD_STAT_BUS32] = bus32_r;
            rd_mux[PAD_STAT_RGN_LO +: 4] = region_r;
        end
        if (haddr[31:8] != 24'h00_0000)
            rd_mux = 32'h0000_0000;
    end

    // read data is registered so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else if (ahb_rd)
            hrdata_r <= rd_mux;
    end

    // decoded selects, one cycle after the access is offered
    // one-cycle pulse per accepted access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rom_n_r    <= 4'hF;
            dram_n_r   <= 4'hF;
            disp_n_r   <= 1'b1;
            isaio_n_r  <= 1'b1;
            isamem_n_r <= 1'b1;
            io1_n_r    <= '1;
            io2_n_r    <= '1;
        end else if (acc_valid) begin
            rom_n_r    <= ~rom_hit;
            dram_n_r   <= ~dram_hit;
            disp_n_r   <= disp_n_nxt;
            isaio_n_r  <= !in_isaio;
            isamem_n_r <= isamem_n_nxt;
            io1_n_r    <= ~io1_hit;
            io2_n_r    <= ~io2_hit;
        end else begin
            // no access: all selects idle high
            rom_n_r    <= 4'hF;
            dram_n_r   <= 4'hF;
            disp_n_r   <= 1'b1;
            isaio_n_r  <= 1'b1;
            isamem_n_r <= 1'b1;
            io1_n_r    <= '1;
            io2_n_r    <= '1;
        end
    end

    // address, data, wait and region captured per access
    // held so slow parts see stable lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_addr_r  <= 26'h000_0000;
            ext_wdata_r <= 32'h0000_0000;
            wait_r      <= '0;
            region_r    <= PAD_RGN_NONE;
        end else if (acc_valid) begin
            ext_addr_r  <= ext_addr_nxt;
            ext_wdata_r <= ext_wdata_nxt;
            wait_r      <= wait_nxt;
            region_r    <= rgn;
        end
    end

    // read data returns inverted from the display window
    // taken every cycle; caller picks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            acc_rdata_r <= 32'h0000_0000;
        else
            acc_rdata_r <= lcd_last ? ~ext_rdata : ext_rdata;
    end

    // outputs; no wait states, never an error
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = hrdata_r;

    // decode results, all from flops
    assign acc_rdata         = acc_rdata_r;
    assign ext_addr          = ext_addr_r;
    assign ext_wdata         = ext_wdata_r;
    assign rom_bank_select_n = rom_n_r;
    assign dram_row_strobe_n = dram_n_r;
    assign display_select_n  = disp_n_r;
    assign isa_io_select_n   = isaio_n_r;
    assign isa_mem_select_n  = isamem_n_r;
    assign acc_wait          = wait_r;
    assign io1_select_n      = io1_n_r;
    assign io2_select_n      = io2_n_r;
    assign region            = region_r;
endmodule

// >>> tb/pad_decoder_chk.sv
`timescale 1ns/1ps
// decode timing and select properties seen at the decoder ports
module pad_decoder_chk
    import pad_pkg::*;
(
    // clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // access port
    input wire logic                 acc_valid,
    input wire logic [31:0]          acc_addr,
    input wire logic [31:0]          acc_wdata,
    input wire logic [31:0]          acc_rdata,
    // external side
    input wire logic [25:0]          ext_addr,
    input wire logic [31:0]          ext_wdata,
    input wire logic [31:0]          ext_rdata,
    input wire logic [3:0]           rom_bank_select_n,
    input wire logic [3:0]           dram_row_strobe_n,
    input wire logic                 display_select_n,
    input wire logic                 isa_io_select_n,
    input wire logic                 isa_mem_select_n,
    // internal selects and region
    input wire logic [PAD_IO1_N-1:0] io1_select_n,
    input wire logic [PAD_IO2_N-1:0] io2_select_n,
    input wire pad_region_t          region
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // views of the request used one cycle later
    wire [25:0] low_addr = acc_addr[25:0];
    wire [25:0] hs_addr  = {2'h2, acc_addr[23:0]};
    wire [31:0] inv_wd   = ~acc_wdata;
    wire [31:0] inv_rd   = ~ext_rdata;
    wire [2:0]  io1_exp  = ~(3'h1 << acc_addr[6:5]);
    wire        shared   = acc_addr[28:24] == 5'h0A;

    chk_sel_pulse: assert property (!acc_valid |=> &rom_bank_select_n
        && &dram_row_strobe_n && display_select_n && isa_io_select_n
        && isa_mem_select_n && &io1_select_n && &io2_select_n)
        else $error("select outside an access cycle");
    chk_rom_rsvd: assert property (acc_valid && acc_addr[28:27] == 2'h3
        && acc_addr[26:25] != 2'h3 |=> &rom_bank_select_n)
        else $error("rom bank in reserved rom range");
    chk_dram_rsvd: assert property (acc_valid && acc_addr[28:25] == 4'h1
        |=> &dram_row_strobe_n && region == PAD_RGN_NONE)
        else $error("dram strobe in reserved range");
    chk_rom_addr: assert property (acc_valid && acc_addr[28:27] == 2'h3
        |=> ext_addr == $past(low_addr))
        else $error("rom external address wrong");
    chk_hs_addr: assert property (acc_valid && shared ##1
        region == PAD_RGN_HSMEM |-> ext_addr == $past(hs_addr))
        else $error("fast window address pattern wrong");
    chk_disp_sel: assert property (acc_valid && shared |=> !display_select_n
        && (region == PAD_RGN_HSMEM) == !isa_mem_select_n)
        else $error("shared window selects wrong");
    chk_lcd_wdata: assert property (acc_valid ##1 region == PAD_RGN_LCD
        |-> ext_wdata == $past(inv_wd))
        else $error("display write data not inverted");
    chk_lcd_rdata: assert property (region == PAD_RGN_LCD
        |=> acc_rdata == $past(inv_rd))
        else $error("display read data not inverted");
    chk_io1_sel: assert property (acc_valid && acc_addr[28:24] == 5'h0C
        && acc_addr[23:0] < 24'h60 |=> io1_select_n == $past(io1_exp))
        else $error("io space 1 select wrong");
    chk_isa_io: assert property (acc_valid && acc_addr[28:26] == 3'h5
        |=> !isa_io_select_n && region == PAD_RGN_ISAIO)
        else $error("system bus io select wrong");
    // main scenarios reached
    cov_rom: cover property (!(&rom_bank_select_n));
    cov_lcd: cover property (region == PAD_RGN_LCD);
    cov_fast: cover property (region == PAD_RGN_HSMEM);
endmodule

bind pad_decoder pad_decoder_chk i_pad_decoder_chk (
    .hclk, .hresetn, .acc_valid, .acc_addr, .acc_wdata, .acc_rdata,
    .ext_addr, .ext_wdata, .ext_rdata, .rom_bank_select_n,
    .dram_row_strobe_n, .display_select_n, .isa_io_select_n,
    .isa_mem_select_n, .io1_select_n, .io2_select_n, .region
);

// >>> tb/pad_ext_model.sv
`timescale 1ns/1ps
// rom, dram, system bus and display parts behind the decoder
module pad_ext_model (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // decoder outputs
    input  wire logic [25:0] ext_addr,
    input  wire logic [3:0]  rom_bank_select_n,
    input  wire logic [3:0]  dram_row_strobe_n,
    input  wire logic        display_select_n,
    input  wire logic        isa_io_select_n,
    input  wire logic        isa_mem_select_n,
    // read data
    output logic      [31:0] ext_rdata
);
    logic        sel;
    logic [31:0] idle_r;
    // a selected part answers with a word derived from its address
    assign sel = !(&rom_bank_select_n && &dram_row_strobe_n
        && display_select_n && isa_io_select_n && isa_mem_select_n);
    assign ext_rdata = sel ? {6'h15, ext_addr} : idle_r;
    // released bus shows a pattern that flips every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            idle_r <= 32'hA5A5_0F0F;
        else
            idle_r <= ~idle_r;
    end
endmodule

// >>> tb/pad_decoder_tb_top.sv
`timescale 1ns/1ps
module pad_decoder_tb_top
    import pad_pkg::*;
;
    logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic                 bus_width_strap, acc_valid, display_select_n;
    logic                 isa_io_select_n, isa_mem_select_n, b32;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [31:0]          haddr, hwdata, hrdata, acc_addr, acc_wdata;
    logic [31:0]          acc_rdata, ext_wdata, ext_rdata, ctrl, rd;
    logic [25:0]          ext_addr;
    logic [3:0]           rom_bank_select_n, dram_row_strobe_n, acc_wait;
    logic [PAD_IO1_N-1:0] io1_select_n;
    logic [PAD_IO2_N-1:0] io2_select_n;
    pad_region_t          region;
    int                   errors, cmp_count, seed;

    // decoder and the parts behind it
    pad_decoder i_pad_decoder (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bus_width_strap,
        .acc_valid, .acc_addr, .acc_wdata, .acc_rdata, .ext_addr, .ext_wdata,
        .ext_rdata, .rom_bank_select_n, .dram_row_strobe_n, .display_select_n,
        .isa_io_select_n, .isa_mem_select_n, .acc_wait, .io1_select_n,
        .io2_select_n, .region
    );
    pad_ext_model i_pad_ext_model (
        .hclk, .hresetn, .ext_addr, .rom_bank_select_n, .dram_row_strobe_n,
        .display_select_n, .isa_io_select_n, .isa_mem_select_n, .ext_rdata
    );

    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 64) begin
                errors++;
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask

    // one single ahb-lite word transfer
    task automatic ahb(logic wr, logic [7:0] ad, logic [31:0] wd,
                       output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdat = hrdata;
        check("hresp", hresp, 64'h0);
    endtask

    // expected {region, rom, dram, display, isa io, isa mem, io1, io2}
    function automatic logic [39:0] exp_dec(logic [28:0] a, logic w32,
                                            logic r64, d64, hs);
        logic [3:0]  rg, rm, dm;
        logic [2:0]  s1;
        logic [21:0] s2;
        logic        dp, io, mm;
        logic [28:0] bs, lim;
        int          sh;
        rg = 4'h0;
        {rm, dm, dp, io, mm, s1, s2} = '1;
        bs = r64 ? 29'h1E00_0000 : 29'h1F00_0000;
        sh = 22 + r64 + w32;
        if (a >= bs) begin
            rg = 4'h2;
            rm = ~(4'h1 << ((a - bs) >> sh));
        end
        sh = 21 + 2 * d64 + w32;
        lim = (w32 ? 29'h2 : 29'h4) << sh;
        if (a < lim) begin
            rg = 4'h1;
            dm = ~(4'h1 << (a >> sh));
        end
        if (a[28:26] == 3'h5) begin
            rg = 4'h3;
            io = 1'b0;
        end
        if (a[28:26] == 3'h4) begin
            rg = 4'h4;
            mm = 1'b0;
        end
        if (a[28:24] == 5'h0A) begin
            rg = hs ? 4'h5 : 4'h6;
            dp = 1'b0;
            mm = !hs;
        end
        if (a[28:24] == 5'h0C && a[23:0] < 24'h60) begin
            rg = 4'h7;
            s1[a[6:5]] = 1'b0;
        end
        if (a[28:24] == 5'h0B && a[23:0] < 24'h2C0 &&
            !(a[9:5] inside {10, 15, 17, 20})) begin
            rg = 4'h8;
            s2[a[9:5]] = 1'b0;
        end
        return {rg, rm, dm, dp, io, mm, s1, s2};
    endfunction

    // one access with random alias bits and data
    task automatic access(logic [31:0] ad);
        logic [39:0] e;
        logic [31:0] wd;
        logic [25:0] xa;
        ad[31:29] = 3'($random(seed));
        wd = $random(seed);
        e = exp_dec(ad[28:0], b32, ctrl[0], ctrl[1], ctrl[2]);
        xa = (e[39:36] == 4'h5) ? {2'h2, ad[23:0]} : ad[25:0];
        @(posedge hclk);
        acc_valid <= 1'b1;
        acc_addr <= ad;
        acc_wdata <= wd;
        @(posedge hclk);
        acc_valid <= 1'b0;
        #1;
        check("decode", {region, rom_bank_select_n, dram_row_strobe_n,
              display_select_n, isa_io_select_n, isa_mem_select_n,
              io1_select_n, io2_select_n}, e);
        check("ext_addr", ext_addr, xa);
        check("ext_wdata", ext_wdata, wd ^ {32{e[39:36] == 4'h6}});
        check("acc_wait", acc_wait,
              (e[39:36] == 4'h5) ? ctrl[7:4] : ctrl[11:8]);
        @(posedge hclk);
        #1;
        if (e[39:36] inside {[4'h1:4'h6]})
            check("acc_rdata", acc_rdata,
                  {6'h15, xa} ^ {32{e[39:36] == 4'h6}});
    endtask

    // main sequence
    initial begin
        seed = 32'h19F3F8EA;
        hresetn <= 1'b0;
        {hsel, hwrite, bus_width_strap, acc_valid} <= 4'h0;
        htrans <= 2'h0;
        hsize <= 3'h2;
        {haddr, hwdata, acc_addr, acc_wdata} <= '0;
        ctrl = 32'h0;
        b32 = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, PAD_CTRL_OFS, 32'h0, rd);
        check("ctrl_rst", rd, 32'h0);
        ahb(1'b1, PAD_CTRL_OFS, 32'hFFFF_FFFF, rd);
        ahb(1'b1, 8'h08, 32'h0, rd);
        ahb(1'b0, 8'h08, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        ahb(1'b0, PAD_CTRL_OFS, 32'h0, rd);
        check("ctrl_rw", rd, 32'h0000_0FF7);
        for (int c = 0; c < 16; c++) begin
            b32 = c[0];
            ctrl = {20'h0, 4'($random(seed)), 4'($random(seed)), 1'b0,
                    3'(c >> 1)};
            @(posedge hclk);
            bus_width_strap <= c[0];
            ahb(1'b1, PAD_CTRL_OFS, ctrl, rd);
            repeat (4) @(posedge hclk);
            ahb(1'b0, PAD_STAT_OFS, 32'h0, rd);
            check("bus32", rd[0], b32);
            for (int i = 0; i < 32; i++) begin
                access(i << 21);
                access((i << 21) - 1);
                access(32'h1800_0000 + (i << 22));
                access(32'h17FF_FFFF + (i << 22));
                access(i << 24);
                access((i << 24) - 1);
                if (i < 24) begin
                    access(32'h0B00_0000 + i * 32 + 31);
                    access(32'h0C00_0000 + i * 32);
                end
                access($random(seed));
            end
        end
        give_verdict();
    end
endmodule
